// ===== hdl/uwf_defs.vh
// Contract
// - Separate 16 by 8-bit transmit and receive FIFOs
// - FIFO disable gives one-character holding register
// - Thresholds at 1/8,1/4,1/2,3/4,7/8 of depth
// - Five to eight data bits, start and stop
// - Even, odd, stick or no parity
// - One or two stop bits on transmit
// - Send break on request, detect received break
// - RTS shows room, CTS high withholds transmit
// - Interrupts on FIFO threshold and transmit end
// - Separate transmit and receive DMA channels
// - Receive single when data, burst at level
// - Transmit single when space, burst at level
// - Programmable bit rate up to three Mbps; at 20 MHz the divider reaches 1.25 Mbps at most
// - Bit timing divided from the system clock
`ifndef UWF_DEFS_VH
`define UWF_DEFS_VH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define UWF_A_DATA 8'h00
`define UWF_A_STAT 8'h04
`define UWF_A_BAUD 8'h08
`define UWF_A_LINE 8'h0C
`define UWF_A_LVL 8'h10
`define UWF_A_IST 8'h14
`define UWF_A_IMSK 8'h18
`define UWF_A_DMA 8'h1C
// ---------------------------------------------------------------
// Line control field positions
// ---------------------------------------------------------------
`define UWF_L_PEN 2
`define UWF_L_EVEN 3
`define UWF_L_STICK 4
`define UWF_L_STOP2 5
`define UWF_L_BRK 6
`define UWF_L_FEN 7
`define UWF_L_FLOW 8
`define UWF_L_EN 9
// ---------------------------------------------------------------
// Interrupt status bit positions
// ---------------------------------------------------------------
`define UWF_I_RXL 0
`define UWF_I_TXL 1
`define UWF_I_EOT 2
`define UWF_I_OVR 3
`define UWF_I_FRM 4
`define UWF_I_PAR 5
`define UWF_I_BRK 6
// ---------------------------------------------------------------
// Reset values, sizes and timing
// ---------------------------------------------------------------
`define UWF_BAUD_RST 16'h000B
`define UWF_LINE_RST 10'h283
`define UWF_LVL_RST 6'h12
`define UWF_DEPTH 5'h10
`define UWF_OVS_LAST 4'hF
`define UWF_OVS_MID 4'h7
`define UWF_CLK_HZ 20000000
`define UWF_MAX_BPS 3000000
`define UWF_MIN_DIV ((`UWF_CLK_HZ + 16 * `UWF_MAX_BPS - 1) / (16 * `UWF_MAX_BPS))
`endif

// ===== hdl/uwf_top.v
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "uwf_defs.vh"
module uwf_top (
   input wire clk_sys, // System clock, 20 MHz
   input wire rst_n, // Asynchronous reset, active low
   input wire hsel, // AHB slave select
   input wire [31:0] haddr, // AHB address
   input wire [1:0] htrans, // AHB transfer type
   input wire hwrite, // AHB write flag
   input wire [2:0] hsize, // AHB size, word only
   input wire [31:0] hwdata, // AHB write data
   input wire hready, // AHB bus ready
   output reg [31:0] hrdata, // AHB read data
   output reg hreadyout, // AHB slave ready
   output reg hresp, // AHB response, always OKAY
   input wire rxd, // Serial receive line
   output reg txd, // Serial transmit line
   input wire cts_n, // Clear to send, low allows transmit
   output reg rts_n, // Ready to send, low while room
   output reg irq, // Level interrupt
   output reg dma_rx_single, // Receive single request
   output reg dma_rx_burst, // Receive burst request
   output reg dma_tx_single, // Transmit single request
   output reg dma_tx_burst // Transmit burst request
);
   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam S_IDLE = 3'd0;
   localparam S_START = 3'd1;
   localparam S_DATA = 3'd2;
   localparam S_PAR = 3'd3;
   localparam S_STOP = 3'd4;
   localparam S_STOP2 = 3'd5;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg [15:0] baud_reg; // Oversample divisor
   reg [9:0] line_reg; // Frame format and control
   reg [5:0] lvl_reg; // Threshold selects, rx high, tx low
   reg [6:0] ist_reg; // Sticky interrupt status
   reg [6:0] imsk_reg; // Interrupt mask
   reg [1:0] dma_reg; // DMA enables, bit 1 tx, bit 0 rx
   reg dph_reg; // Data phase pending
   reg dwr_reg; // Pending phase is a write
   reg [7:0] dad_reg; // Pending byte offset
   wire fen = line_reg[`UWF_L_FEN];
   wire [4:0] cap = fen ? `UWF_DEPTH : 5'h01;
   wire [3:0] nbits = {2'b00, line_reg[1:0]} + 4'd5;

   // ---------------------------------------------------------------
   // FIFOs, index 0 transmit, index 1 receive
   // ---------------------------------------------------------------
   wire [10:0] f_wdata [0:1]; // Write word
   wire [10:0] f_rdata [0:1]; // Head word
   wire [4:0] f_cnt [0:1]; // Fill count
   wire f_push [0:1]; // Write strobe
   wire f_pop [0:1]; // Read strobe
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_fifo
         reg [10:0] mem [0:15]; // Storage, 16 entries
         reg [3:0] wp_reg; // Write pointer
         reg [3:0] rp_reg; // Read pointer
         reg [4:0] cnt_reg; // Entries held
         wire wr = f_push[gi] && (cnt_reg < cap);
         wire rd = f_pop[gi] && (cnt_reg != 5'h00);
         // Storage has no reset; only counted entries are ever read
         always @(posedge clk_sys) begin
            if (wr) begin
               mem[wp_reg] <= f_wdata[gi];
            end
         end
         // Pointers and count
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               wp_reg <= 4'h0;
               rp_reg <= 4'h0;
               cnt_reg <= 5'h00;
            end else begin
               if (wr) begin
                  wp_reg <= wp_reg + 4'h1;
               end
               if (rd) begin
                  rp_reg <= rp_reg + 4'h1;
               end
               cnt_reg <= cnt_reg + {4'h0, wr} - {4'h0, rd};
            end
         end
         assign f_rdata[gi] = mem[rp_reg];
         assign f_cnt[gi] = cnt_reg;
      end
   endgenerate
   wire tx_full = f_cnt[0] >= cap;
   wire tx_empty = f_cnt[0] == 5'h00;
   wire rx_full = f_cnt[1] >= cap;
   wire rx_empty = f_cnt[1] == 5'h00;

   // Threshold in entries: 2,4,8,12,14 of 16; one entry without FIFO
   function [4:0] thr;
      input [2:0] sel;
      input fe;
      begin
         case (sel)
            3'd0: thr = 5'd2;
            3'd1: thr = 5'd4;
            3'd2: thr = 5'd8;
            3'd3: thr = 5'd12;
            default: thr = 5'd14;
         endcase
         if (!fe) begin
            thr = 5'd1;
         end
      end
   endfunction
   wire rx_lvl = f_cnt[1] >= thr(lvl_reg[5:3], fen);
   wire tx_lvl = f_cnt[0] <= thr(lvl_reg[2:0], fen) - 5'd1;

   // ---------------------------------------------------------------
   // Bit-rate generator
   // ---------------------------------------------------------------
   reg [15:0] bdiv_reg; // Down counter
   reg tick; // Sixteen-times bit rate enable
   // Divisor 0 behaves as 1; at 20 MHz the fastest line is 1.25 Mbps
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bdiv_reg <= 16'h0000;
         tick <= 1'b0;
      end else if (bdiv_reg == 16'h0000) begin
         bdiv_reg <= (baud_reg == 16'h0000) ? 16'h0000 : baud_reg - 16'h0001;
         tick <= 1'b1;
      end else begin
         bdiv_reg <= bdiv_reg - 16'h0001;
         tick <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Transmitter
   // ---------------------------------------------------------------
   reg [2:0] ts_reg; // State
   reg [3:0] tsub_reg; // Oversample phase
   reg [3:0] tbit_reg; // Data bits sent
   reg [7:0] tsh_reg; // Shift register
   reg tpar_reg; // Parity to send
   reg tline_reg; // Line level before break
   reg eot_ev; // End of transmission event
   wire tgo = line_reg[`UWF_L_EN] && !tx_empty && (!line_reg[`UWF_L_FLOW] || !cts_n);
   wire tend = tick && tsub_reg == `UWF_OVS_LAST;
   wire [7:0] tdat = f_rdata[0][7:0];
   wire [7:0] tmask = 8'hFF >> (4'd8 - nbits);
   assign f_pop[0] = (ts_reg == S_IDLE) && tgo;
   // Frame sequencer; CTS is only looked at between characters
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ts_reg <= S_IDLE;
         tsub_reg <= 4'h0;
         tbit_reg <= 4'h0;
         tsh_reg <= 8'h00;
         tpar_reg <= 1'b0;
         tline_reg <= 1'b1;
         eot_ev <= 1'b0;
      end else begin
         eot_ev <= 1'b0;
         if (tick) begin
            tsub_reg <= tsub_reg + 4'h1;
         end
         case (ts_reg)
            S_IDLE: begin
               tline_reg <= 1'b1;
               if (tgo) begin
                  tsh_reg <= tdat;
                  if (line_reg[`UWF_L_STICK]) begin
                     tpar_reg <= !line_reg[`UWF_L_EVEN];
                  end else begin
                     tpar_reg <= (^(tdat & tmask)) ^ !line_reg[`UWF_L_EVEN];
                  end
                  tsub_reg <= 4'h0;
                  tbit_reg <= 4'h0;
                  tline_reg <= 1'b0;
                  ts_reg <= S_START;
               end
            end
            S_START: begin
               if (tend) begin
                  tline_reg <= tsh_reg[0];
                  ts_reg <= S_DATA;
               end
            end
            S_DATA: begin
               if (tend) begin
                  tsh_reg <= {1'b0, tsh_reg[7:1]};
                  tbit_reg <= tbit_reg + 4'h1;
                  if (tbit_reg + 4'h1 == nbits) begin
                     tline_reg <= line_reg[`UWF_L_PEN] ? tpar_reg : 1'b1;
                     ts_reg <= line_reg[`UWF_L_PEN] ? S_PAR : S_STOP;
                  end else begin
                     tline_reg <= tsh_reg[1];
                  end
               end
            end
            S_PAR: begin
               if (tend) begin
                  tline_reg <= 1'b1;
                  ts_reg <= S_STOP;
               end
            end
            S_STOP: begin
               if (tend) begin
                  ts_reg <= line_reg[`UWF_L_STOP2] ? S_STOP2 : S_IDLE;
                  eot_ev <= !line_reg[`UWF_L_STOP2] && tx_empty;
               end
            end
            S_STOP2: begin
               if (tend) begin
                  ts_reg <= S_IDLE;
                  eot_ev <= tx_empty;
               end
            end
            default: ts_reg <= S_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Receiver
   // ---------------------------------------------------------------
   reg [2:0] rs_reg; // State
   reg [3:0] rsub_reg; // Oversample phase
   reg [3:0] rbit_reg; // Data bits taken
   reg [7:0] rsh_reg; // Assembled character
   reg rpe_reg; // Parity error of this character
   reg rprev_reg; // Previous line level for edge detect
   reg rx_push; // Character complete
   reg [10:0] rword_reg; // Break, parity, framing and data
   reg ovr_ev; // Overrun event
   wire rmid = tick && rsub_reg == `UWF_OVS_LAST;
   wire [7:0] rpos = rsh_reg;
   wire rstop_bad = !rxd;
   assign f_push[1] = rx_push;
   assign f_wdata[1] = rword_reg;
   // Start found on a falling edge, confirmed at half a bit, then each bit taken at its centre
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rs_reg <= S_IDLE;
         rsub_reg <= 4'h0;
         rbit_reg <= 4'h0;
         rsh_reg <= 8'h00;
         rpe_reg <= 1'b0;
         rprev_reg <= 1'b1;
         rx_push <= 1'b0;
         rword_reg <= 11'h000;
         ovr_ev <= 1'b0;
      end else begin
         rprev_reg <= rxd;
         rx_push <= 1'b0;
         ovr_ev <= 1'b0;
         if (tick) begin
            rsub_reg <= rsub_reg + 4'h1;
         end
         case (rs_reg)
            S_IDLE: begin
               if (line_reg[`UWF_L_EN] && rprev_reg && !rxd) begin
                  rsub_reg <= 4'h0;
                  rbit_reg <= 4'h0;
                  rsh_reg <= 8'h00;
                  rs_reg <= S_START;
               end
            end
            S_START: begin
               if (tick && rsub_reg == `UWF_OVS_MID) begin
                  rsub_reg <= 4'h0;
                  rs_reg <= rxd ? S_IDLE : S_DATA;
               end
            end
            S_DATA: begin
               if (rmid) begin
                  rsh_reg <= rsh_reg | ({7'h00, rxd} << rbit_reg[2:0]);
                  rbit_reg <= rbit_reg + 4'h1;
                  if (rbit_reg + 4'h1 == nbits) begin
                     rs_reg <= line_reg[`UWF_L_PEN] ? S_PAR : S_STOP;
                  end
               end
            end
            S_PAR: begin
               if (rmid) begin
                  if (line_reg[`UWF_L_STICK]) begin
                     rpe_reg <= rxd != !line_reg[`UWF_L_EVEN];
                  end else begin
                     rpe_reg <= (^rpos ^ rxd) != !line_reg[`UWF_L_EVEN];
                  end
                  rs_reg <= S_STOP;
               end
            end
            S_STOP: begin
               if (rmid) begin
                  // Break: data, parity and stop all low
                  rword_reg <= {rstop_bad && rpos == 8'h00 &&
                                (!line_reg[`UWF_L_PEN] || rpe_reg == !line_reg[`UWF_L_EVEN]),
                                line_reg[`UWF_L_PEN] && rpe_reg, rstop_bad, rpos};
                  rx_push <= 1'b1;
                  ovr_ev <= rx_full;
                  rpe_reg <= 1'b0;
                  rs_reg <= S_IDLE;
               end
            end
            default: rs_reg <= S_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Bus slave, zero wait states
   // ---------------------------------------------------------------
   wire aph = hsel && htrans[1] && hready;
   wire wr_do = dph_reg && dwr_reg;
   assign f_push[0] = wr_do && dad_reg == `UWF_A_DATA;
   assign f_wdata[0] = {3'b000, hwdata[7:0]};
   assign f_pop[1] = aph && !hwrite && haddr[7:0] == `UWF_A_DATA;
   reg rxl_prev; // Previous receive level condition
   reg txl_prev; // Previous transmit level condition
   wire [6:0] iev = {rword_reg[10] & rx_push, rword_reg[9] & rx_push, rword_reg[8] & rx_push, ovr_ev, eot_ev,
                     tx_lvl & !txl_prev, rx_lvl & !rxl_prev};
   wire [6:0] iclr = (wr_do && dad_reg == `UWF_A_IST) ? hwdata[6:0] : 7'h00;
   wire [6:0] ist_next = (ist_reg & ~iclr) | iev; // Set wins over clear
   // Read data is captured in the address phase so hrdata leaves a flop
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         dph_reg <= 1'b0;
         dwr_reg <= 1'b0;
         dad_reg <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         dph_reg <= aph;
         dwr_reg <= hwrite;
         dad_reg <= haddr[7:0];
         if (aph && !hwrite) begin
            case (haddr[7:0])
               `UWF_A_DATA: hrdata <= rx_empty ? 32'h00000000 : {21'h000000, f_rdata[1]};
               `UWF_A_STAT: hrdata <= {25'h0000000, ts_reg != S_IDLE, !cts_n, rx_full, rx_empty, tx_full, tx_empty,
                                       rs_reg != S_IDLE};
               `UWF_A_BAUD: hrdata <= {16'h0000, baud_reg};
               `UWF_A_LINE: hrdata <= {22'h000000, line_reg};
               `UWF_A_LVL: hrdata <= {26'h0000000, lvl_reg};
               `UWF_A_IST: hrdata <= {25'h0000000, ist_reg};
               `UWF_A_IMSK: hrdata <= {25'h0000000, imsk_reg};
               `UWF_A_DMA: hrdata <= {30'h00000000, dma_reg};
               default: hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Register writes in the data phase; unmapped writes are dropped
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         baud_reg <= `UWF_BAUD_RST;
         line_reg <= `UWF_LINE_RST;
         lvl_reg <= `UWF_LVL_RST;
         imsk_reg <= 7'h00;
         dma_reg <= 2'b00;
      end else if (wr_do) begin
         case (dad_reg)
            `UWF_A_BAUD: baud_reg <= hwdata[15:0];
            `UWF_A_LINE: line_reg <= hwdata[9:0];
            `UWF_A_LVL: lvl_reg <= hwdata[5:0];
            `UWF_A_IMSK: imsk_reg <= hwdata[6:0];
            `UWF_A_DMA: dma_reg <= hwdata[1:0];
            default: dma_reg <= dma_reg;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Interrupts, DMA requests and line outputs
   // ---------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ist_reg <= 7'h00;
         rxl_prev <= 1'b0;
         txl_prev <= 1'b0;
         irq <= 1'b0;
         dma_rx_single <= 1'b0;
         dma_rx_burst <= 1'b0;
         dma_tx_single <= 1'b0;
         dma_tx_burst <= 1'b0;
         txd <= 1'b1;
         rts_n <= 1'b1;
      end else begin
         ist_reg <= ist_next;
         rxl_prev <= rx_lvl;
         txl_prev <= tx_lvl;
         irq <= |(ist_next & imsk_reg);
         dma_rx_single <= dma_reg[0] && !rx_empty;
         dma_rx_burst <= dma_reg[0] && rx_lvl;
         dma_tx_single <= dma_reg[1] && !tx_full;
         dma_tx_burst <= dma_reg[1] && tx_lvl;
         txd <= tline_reg && !line_reg[`UWF_L_BRK];
         rts_n <= line_reg[`UWF_L_FLOW] && rx_full;
      end
   end
endmodule // uwf_top

// ===== sim/uwf_chk_sva.sv
`timescale 1ns/10ps
module uwf_chk (
   input wire clk_sys, // Clock
   input wire rst_n, // Reset, active low
   input wire hsel, // Select
   input wire [31:0] haddr, // Address
   input wire [1:0] htrans, // Transfer type
   input wire hwrite, // Write flag
   input wire [31:0] hwdata, // Write data
   input wire hready, // Bus ready
   input wire [31:0] hrdata, // Read data
   input wire hreadyout, // Slave ready
   input wire hresp, // Response
   input wire txd, // Serial out
   input wire irq, // Interrupt
   input wire dma_rx_single, // Rx single
   input wire dma_rx_burst, // Rx burst
   input wire dma_tx_single, // Tx single
   input wire dma_tx_burst // Tx burst
);
   // -------
   // Taken address phases
   // -------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   wire rd_take = hsel && htrans[1] && hready && !hwrite; // Read taken
   wire wr_take = hsel && htrans[1] && hready && hwrite; // Write taken
   wire dma_any = dma_rx_single | dma_rx_burst | dma_tx_single | dma_tx_burst; // Any request
   a_ready_always: assert property (hreadyout) else $error("slave inserted a wait");
   a_resp_okay: assert property (!hresp) else $error("response not okay");
   a_rdata_hold: assert property (!rd_take |=> $stable(hrdata)) else $error("read data moved");
   a_unmapped_zero: assert property (rd_take && haddr[7:0] > 8'h1C |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_rx_burst_single: assert property (dma_rx_burst |-> dma_rx_single) else $error("rx burst alone");
   a_tx_burst_single: assert property (dma_tx_burst |-> dma_tx_single) else $error("tx burst alone");
   a_space_len: assert property ($fell(txd) |-> (!txd)[*8] ##1 (!txd)[*8]) else $error("low bit short");
   a_mark_len: assert property ($rose(txd) |-> txd[*8] ##1 txd[*8]) else $error("high bit short");
   a_mask_off_irq: assert property (wr_take && haddr[7:0] == 8'h18 ##1 hwdata == 32'h0 |=> ##[0:2] !irq)
      else $error("irq stayed with mask clear");
   a_dma_off: assert property (wr_take && haddr[7:0] == 8'h1C ##1 hwdata[1:0] == 2'h0 |=> ##[0:2] !dma_any)
      else $error("dma request stayed disabled");
   cover property ($rose(irq));
   cover property ($rose(dma_rx_burst));
   cover property ($fell(txd));
   cover property (dma_tx_burst);
endmodule // uwf_chk
bind uwf_top uwf_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .txd(txd), .irq(irq), .dma_rx_single(dma_rx_single), .dma_rx_burst(dma_rx_burst),
   .dma_tx_single(dma_tx_single), .dma_tx_burst(dma_tx_burst));

// ===== sim/uwf_peer.sv
`timescale 1ns/10ps
module uwf_peer #(
   parameter BIT = 16 // Clocks per bit
) (
   input wire clk_sys, // Clock
   input wire txd, // Line from the block
   output reg rxd, // Line to the block
   output reg cts_n // Clear to send
);
   reg [15:0] cap; // Bits after start
   reg [15:0] q [$]; // Captured frames
   integer ncap; // Bits captured per frame
   integer i; // Bit index
   // -------
   // Idle line, transmit allowed
   // -------
   initial begin
      rxd = 1'b1;
      cts_n = 1'b0;
      ncap = 9;
   end
   // Sample at bit centres; stop bits are kept so short stops show up
   initial begin
      forever begin
         @(negedge txd);
         repeat (BIT / 2) @(posedge clk_sys);
         cap = 16'h0;
         for (i = 0; i < ncap; i = i + 1) begin
            repeat (BIT) @(posedge clk_sys);
            cap[i] = txd;
         end
         q.push_back(cap);
      end
   end
   // Start bit, then n bits LSB first, line left high
   task send(input [15:0] bits, input integer n);
      integer k;
      begin
         @(posedge clk_sys);
         rxd <= 1'b0;
         for (k = 0; k < n; k = k + 1) begin
            repeat (BIT) @(posedge clk_sys);
            rxd <= bits[k];
         end
         repeat (BIT) @(posedge clk_sys);
         rxd <= 1'b1;
      end
   endtask
endmodule // uwf_peer

// ===== sim/uwf_top_tb.sv
`timescale 1ns/10ps
`include "uwf_defs.vh"
module uwf_top_tb;
   localparam [29:0] CFGS = {6'h36, 6'h1E, 6'h05, 6'h2C, 6'h03}; // Frame formats
   localparam [39:0] DATS = {8'h0F, 8'h55, 8'h2E, 8'h13, 8'hA5}; // Payloads
   reg clk_sys = 1'b0;
   reg rst_n = 1'b0;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [2:0] hsize = 3'h2;
   reg [31:0] hwdata = 32'h0;
   wire hready, hreadyout, hresp, rxd, txd, cts_n, rts_n, irq, drs, drb, dts, dtb;
   wire [31:0] hrdata;
   integer errors = 0;
   integer compares = 0;
   integer i, j, n, nb;
   reg [31:0] rd; // Last read data
   reg [15:0] ex; // Expected frame
   reg [5:0] c; // Frame format
   reg [7:0] d; // Payload
   reg p; // Data parity
   always #25 clk_sys = ~clk_sys;
   assign hready = hreadyout; // One slave
   uwf_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .irq(irq), .dma_rx_single(drs), .dma_rx_burst(drb),
      .dma_tx_single(dts), .dma_tx_burst(dtb));
   uwf_peer #(.BIT(16)) peer (.clk_sys(clk_sys), .txd(txd), .rxd(rxd), .cts_n(cts_n));
   // -------
   // Checks and bus cycles
   // -------
   task results;
      if (errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // A spent bound ends the run
   task guard(input integer cnt, input integer lim);
      if (cnt > lim) begin
         errors = errors + 1;
         $display("unexpected at %0t: wait timed out", $time);
         results;
      end
   endtask
   // Address phase held until ready, then data phase held until ready
   task bus(input w, input [7:0] a, input [31:0] wd);
      begin
         @(posedge clk_sys);
         hsel <= 1'b1;
         htrans <= 2'h2;
         haddr <= {24'h0, a};
         hwrite <= w;
         n = 0;
         @(posedge clk_sys);
         while (hready !== 1'b1) begin n = n + 1; guard(n, 100); @(posedge clk_sys); end
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= wd;
         @(posedge clk_sys);
         while (hready !== 1'b1) begin n = n + 1; guard(n, 100); @(posedge clk_sys); end
         rd = hrdata;
      end
   endtask
   task wr(input [7:0] a, input [31:0] v); bus(1'b1, a, v); endtask
   task rdc(input [7:0] a, input [31:0] m, input [31:0] e); bus(1'b0, a, 32'h0); chk(rd & m, e); endtask
   task poll(input [7:0] a, input [31:0] m, input [31:0] e);
      integer t;
      begin
         t = 0;
         bus(1'b0, a, 32'h0);
         while ((rd & m) !== e) begin t = t + 1; guard(t, 300); bus(1'b0, a, 32'h0); end
      end
   endtask
   task waitq(input integer k);
      integer t;
      begin
         t = 0;
         while (peer.q.size() < k) begin t = t + 1; guard(t, 6000); @(posedge clk_sys); end
      end
   endtask
   // -------
   // Main sequence
   // -------
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdc(`UWF_A_BAUD, 32'hFFFFFFFF, 32'h0000000B);
      rdc(`UWF_A_LINE, 32'hFFFFFFFF, 32'h00000283);
      rdc(`UWF_A_LVL, 32'hFFFFFFFF, 32'h00000012);
      rdc(`UWF_A_IMSK, 32'hFFFFFFFF, 32'h0);
      rdc(`UWF_A_DMA, 32'hFFFFFFFF, 32'h0);
      rdc(`UWF_A_STAT, 32'h2E, 32'h2A);
      rdc(8'h20, 32'hFFFFFFFF, 32'h0);
      wr(`UWF_A_BAUD, 32'h1);
      // Each format sent twice back to back so a missing stop bit shows
      for (i = 0; i < 5; i = i + 1) begin
         c = CFGS[i*6 +: 6];
         d = DATS[i*8 +: 8];
         nb = c[1:0] + 5;
         ex = 16'hFFFF;
         for (j = 0; j < nb; j = j + 1) ex[j] = d[j];
         p = ^(d & ((8'h1 << nb) - 8'h1));
         if (c[2]) ex[nb] = c[4] ? !c[3] : (c[3] ? p : !p);
         peer.ncap = nb + c[2] + 1 + c[5];
         ex = ex & ((16'h1 << peer.ncap) - 16'h1);
         wr(`UWF_A_LINE, {22'h0, 4'hA, c});
         wr(`UWF_A_DATA, {24'h0, d});
         wr(`UWF_A_DATA, {24'h0, d});
         waitq(2);
         chk({16'h0, peer.q.pop_front()}, {16'h0, ex});
         chk({16'h0, peer.q.pop_front()}, {16'h0, ex});
      end
      peer.ncap = 9;
      wr(`UWF_A_LINE, 32'h2C3);
      repeat (40) @(posedge clk_sys);
      chk({31'h0, txd}, 32'h0);
      wr(`UWF_A_LINE, 32'h283);
      repeat (200) @(posedge clk_sys);
      peer.q.delete();
      // End of transmission interrupt, raised, cleared and masked
      wr(`UWF_A_IST, 32'h7F);
      wr(`UWF_A_IMSK, 32'h4);
      wr(`UWF_A_DATA, 32'h77);
      waitq(1);
      poll(`UWF_A_IST, 32'h4, 32'h4);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h1);
      wr(`UWF_A_IST, 32'h4);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      wr(`UWF_A_IMSK, 32'h0);
      // Flow control holds the character until clear to send
      peer.q.delete();
      wr(`UWF_A_LINE, 32'h383);
      peer.cts_n <= 1'b1;
      wr(`UWF_A_DATA, 32'h5A);
      repeat (60) @(posedge clk_sys);
      chk(peer.q.size(), 32'h0);
      peer.cts_n <= 1'b0;
      waitq(1);
      chk({16'h0, peer.q.pop_front()}, 32'h15A);
      // Receive: plain, parity error, break
      wr(`UWF_A_LINE, 32'h283);
      peer.send(16'h13C, 9);
      poll(`UWF_A_STAT, 32'h8, 32'h0);
      rdc(`UWF_A_DATA, 32'h7FF, 32'h03C);
      wr(`UWF_A_LINE, 32'h28C);
      peer.send(16'h0053, 7);
      poll(`UWF_A_STAT, 32'h8, 32'h0);
      rdc(`UWF_A_DATA, 32'h7FF, 32'h213);
      wr(`UWF_A_LINE, 32'h283);
      peer.send(16'h0, 12);
      poll(`UWF_A_STAT, 32'h8, 32'h0);
      rdc(`UWF_A_DATA, 32'h7FF, 32'h500);
      rdc(`UWF_A_IST, 32'h70, 32'h70);
      // Holding mode: one character fills it, the next overruns
      wr(`UWF_A_LINE, 32'h303);
      wr(`UWF_A_DMA, 32'h1);
      peer.send(16'h111, 9);
      poll(`UWF_A_STAT, 32'h8, 32'h0);
      repeat (3) @(posedge clk_sys);
      chk({29'h0, rts_n, drs, drb}, 32'h7);
      peer.send(16'h122, 9);
      repeat (40) @(posedge clk_sys);
      rdc(`UWF_A_IST, 32'h8, 32'h8);
      rdc(`UWF_A_DATA, 32'h7FF, 32'h011);
      rdc(`UWF_A_STAT, 32'h8, 32'h8);
      // Transmit queue filled while stopped; the extra write is dropped
      wr(`UWF_A_LINE, 32'h083);
      wr(`UWF_A_DMA, 32'h2);
      wr(`UWF_A_LVL, 32'h14);
      repeat (3) @(posedge clk_sys);
      chk({30'h0, dts, dtb}, 32'h3);
      for (i = 0; i < 17; i = i + 1) begin
         wr(`UWF_A_DATA, i);
         if (i == 12) chk({30'h0, dts, dtb}, 32'h3);
      end
      rdc(`UWF_A_STAT, 32'h6, 32'h4);
      chk({30'h0, dts, dtb}, 32'h0);
      wr(`UWF_A_DMA, 32'h0);
      wr(`UWF_A_LINE, 32'h283);
      waitq(16);
      repeat (400) @(posedge clk_sys);
      chk(peer.q.size(), 32'd16);
      rdc(`UWF_A_IST, 32'h3, 32'h3);
      results;
   end
endmodule // uwf_top_tb
